// *** common/pcfg_params.svh ***
`ifndef PCFG_PARAMS_SVH
`define PCFG_PARAMS_SVH
// dword indices (byte offset / 4) of the config space
`define PCFG_DW_STATCMD   6'h01
`define PCFG_DW_CLASSREV  6'h02
`define PCFG_DW_HDRMISC   6'h03
`define PCFG_DW_IOBASE    6'h04
`define PCFG_DW_MEMBASE   6'h05
`define PCFG_DW_IRQ       6'h0f
// byte offsets as printed
`define PCFG_OFS_REV      8'h08
`define PCFG_OFS_CLASS    8'h09
`define PCFG_OFS_CLS      8'h0c
`define PCFG_OFS_LAT      8'h0d
`define PCFG_OFS_HDR      8'h0e
`define PCFG_OFS_IOBASE   8'h10
`define PCFG_OFS_MEMBASE  8'h14
`define PCFG_OFS_IRQLINE  8'h3c
`define PCFG_OFS_IRQPIN   8'h3d
`define PCFG_OFS_MINGNT   8'h3e
`define PCFG_OFS_MAXLAT   8'h3f
// status field positions
`define PCFG_ST_RTA       12
`define PCFG_ST_SEL_LO    9
`define PCFG_ST_DPR       8
// command field positions
`define PCFG_CMD_PER      6
// fixed values
`define PCFG_SEL_MEDIUM   2'h1
`define PCFG_CLASS_VAL    24'h010000
`define PCFG_HDR_VAL      8'h00
`define PCFG_IRQPIN_VAL   8'h01
`define PCFG_MINGNT_VAL   8'h08
`define PCFG_MAXLAT_VAL   8'h40
`define PCFG_IOBASE_FIX   2'h1
`define PCFG_MEMBASE_FIX  1'h0
`endif

// *** common/pcfg_pkg.sv ***
`default_nettype none
package pcfg_pkg;
	typedef enum logic [1:0] {
		MS_IDLE,
		MS_BURST,
		MS_STOP
	} pcfg_mstate_t;
endpackage : pcfg_pkg
`default_nettype wire

// *** hw/pcfg_header.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_params.svh"
module pcfg_header
	import pcfg_pkg::*;
#(
	parameter logic [3:0] SILICON_REV = 4'h1 // arbitrary value
) (
	input  wire logic        clk,            // bus clock
	input  wire logic        nrst,           // async reset, active low
	input  wire logic        cfg_wr,         // config write strobe
	input  wire logic        cfg_rd,         // config read strobe
	input  wire logic [5:0]  cfg_dw,         // dword index
	input  wire logic [3:0]  cfg_be,         // byte enables, active high
	input  wire logic [31:0] cfg_wdata,      // write data
	output logic      [31:0] cfg_rdata,      // read data
	input  wire logic        per_resp_en,    // command bit 6 from command block
	input  wire logic        cache_line_align_enable, // dma_control_register bit 7
	input  wire logic        core_clk_sel_bus, // use bus clock as core clock
	output logic             core_clk_is_bus,  // core runs on bus clock, slow rates
	input  wire logic        mst_active,     // this device is master of a burst
	input  wire logic        mst_start,      // one-cycle: master tenure begins
	input  wire logic        mst_target_abort, // pulse: own master cycle target-aborted
	input  wire logic        mst_perr_seen,  // pulse: perr driven/observed on own data phase
	input  wire logic        gnt_n,          // arbiter grant, active low
	input  wire logic [31:0] mst_addr,       // current master address
	input  wire logic        memory_to_memory_move, // move with misaligned burst size
	output logic             mst_may_burst,  // alignment permits bursting
	output logic             mst_stop_req,   // end burst now (tenure expired)
	input  wire logic        serr_drive,     // core wants to drive a s/t/s line
	output logic             stl_out_n,      // s/t/s line output value
	output logic             stl_oe,         // s/t/s line output enable
	output logic             rst_sync_n      // synchronised reset, active low
);
	logic       rs1_q, rs2_q;
	logic       rta_q, dpr_q;
	logic [7:0] cls_q, lat_q, irq_line_q;
	logic [31:2] io_base_q;
	logic [31:1] mem_base_q;
	logic [7:0] lat_cnt_q;
	logic [31:0] rdata_d;
	pcfg_mstate_t ms_q;

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
		input logic [3:0] be, input int lane);
		merge_byte = be[lane] ? d[lane*8 +: 8] : old;
	endfunction : merge_byte

	// two-stage reset synchroniser; assert asynchronously, release on clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end
	assign rst_sync_n = rs2_q;

	logic wr_stat, wr_hdr, wr_io, wr_mem, wr_irq;
	assign wr_stat = cfg_wr && cfg_dw == `PCFG_DW_STATCMD;
	assign wr_hdr  = cfg_wr && cfg_dw == `PCFG_DW_HDRMISC;
	assign wr_io   = cfg_wr && cfg_dw == `PCFG_DW_IOBASE;
	assign wr_mem  = cfg_wr && cfg_dw == `PCFG_DW_MEMBASE;
	assign wr_irq  = cfg_wr && cfg_dw == `PCFG_DW_IRQ;

	// status flags: hardware set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			rta_q <= 1'b0;
		end else if (mst_target_abort) begin
			rta_q <= 1'b1;
		end else if (wr_stat && cfg_be[3] && cfg_wdata[16+`PCFG_ST_RTA]) begin
			rta_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			dpr_q <= 1'b0;
		end else if (mst_perr_seen && mst_active && per_resp_en) begin
			dpr_q <= 1'b1;
		end else if (wr_stat && cfg_be[3] && cfg_wdata[16+`PCFG_ST_DPR]) begin
			dpr_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			cls_q <= 8'h00;
			lat_q <= 8'h00;
		end else if (wr_hdr) begin
			cls_q <= merge_byte(cls_q, cfg_wdata, cfg_be, 0);
			lat_q <= merge_byte(lat_q, cfg_wdata, cfg_be, 1);
		end
	end

	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			io_base_q <= '0;
		end else if (wr_io) begin
			io_base_q[7:2]   <= cfg_be[0] ? cfg_wdata[7:2] : io_base_q[7:2];
			io_base_q[15:8]  <= merge_byte(io_base_q[15:8], cfg_wdata, cfg_be, 1);
			io_base_q[23:16] <= merge_byte(io_base_q[23:16], cfg_wdata, cfg_be, 2);
			io_base_q[31:24] <= merge_byte(io_base_q[31:24], cfg_wdata, cfg_be, 3);
		end
	end

	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			mem_base_q <= '0;
		end else if (wr_mem) begin
			mem_base_q[7:1]   <= cfg_be[0] ? cfg_wdata[7:1] : mem_base_q[7:1];
			mem_base_q[15:8]  <= merge_byte(mem_base_q[15:8], cfg_wdata, cfg_be, 1);
			mem_base_q[23:16] <= merge_byte(mem_base_q[23:16], cfg_wdata, cfg_be, 2);
			mem_base_q[31:24] <= merge_byte(mem_base_q[31:24], cfg_wdata, cfg_be, 3);
		end
	end

	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			irq_line_q <= 8'h00;
		end else if (wr_irq) begin
			irq_line_q <= merge_byte(irq_line_q, cfg_wdata, cfg_be, 0);
		end
	end

	// read mux; anything outside the decoded dwords reads zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		case (cfg_dw)
			`PCFG_DW_STATCMD: begin
				rdata_d[16+`PCFG_ST_RTA] = rta_q;
				rdata_d[16+`PCFG_ST_SEL_LO +: 2] = `PCFG_SEL_MEDIUM;
				rdata_d[16+`PCFG_ST_DPR] = dpr_q;
			end
			`PCFG_DW_CLASSREV: rdata_d = {`PCFG_CLASS_VAL, 4'h0, SILICON_REV};
			`PCFG_DW_HDRMISC: rdata_d = {8'h00, `PCFG_HDR_VAL, lat_q, cls_q};
			`PCFG_DW_IOBASE: rdata_d = {io_base_q, `PCFG_IOBASE_FIX};
			`PCFG_DW_MEMBASE: rdata_d = {mem_base_q, `PCFG_MEMBASE_FIX};
			`PCFG_DW_IRQ: rdata_d = {`PCFG_MAXLAT_VAL, `PCFG_MINGNT_VAL,
				`PCFG_IRQPIN_VAL, irq_line_q};
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			cfg_rdata <= 32'h0000_0000;
		end else if (cfg_rd) begin
			cfg_rdata <= rdata_d;
		end
	end

	// tenure timer: loaded at start, counts down each clock while mastering, holds at zero
	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			lat_cnt_q <= 8'h00;
		end else if (mst_start) begin
			lat_cnt_q <= lat_q;
		end else if (mst_active && lat_cnt_q != 8'h00) begin
			lat_cnt_q <= lat_cnt_q - 8'h01;
		end
	end

	always_ff @(posedge clk or negedge rs2_q) begin
		if (!rs2_q) begin
			ms_q <= MS_IDLE;
		end else begin
			case (ms_q)
				MS_IDLE: if (mst_start) ms_q <= MS_BURST;
				MS_BURST: begin
					if (!mst_active) ms_q <= MS_IDLE;
					else if (lat_cnt_q == 8'h00 && gnt_n) ms_q <= MS_STOP;
				end
				MS_STOP: if (!mst_active) ms_q <= MS_IDLE;
				default: ms_q <= MS_IDLE;
			endcase
		end
	end
	assign mst_stop_req = ms_q == MS_STOP;

	// alignment check: only the line-size low bits matter; a zero size disables it
	logic [7:0] line_off;
	assign line_off = mst_addr[9:2] & (cls_q - 8'h01);
	assign mst_may_burst = !cache_line_align_enable || memory_to_memory_move ||
		cls_q == 8'h00 || line_off == 8'h00;

	assign core_clk_is_bus = core_clk_sel_bus;

	// sustained tri-state: only this agent's request drives; floated in reset
	assign stl_oe    = rs2_q && serr_drive;
	assign stl_out_n = 1'b0;

	a_rta_set: assert property (@(posedge clk) disable iff (!rs2_q)
		mst_target_abort |=> rta_q) else $error("target abort flag not set");
	a_dpr_gate: assert property (@(posedge clk) disable iff (!rs2_q)
		$rose(dpr_q) |-> $past(mst_perr_seen && mst_active && per_resp_en))
		else $error("parity reported without cause");
	a_stat_clear: assert property (@(posedge clk) disable iff (!rs2_q)
		wr_stat && cfg_be[3] && cfg_wdata[28] && !mst_target_abort |=> !rta_q)
		else $error("write one did not clear");
	a_no_set: assert property (@(posedge clk) disable iff (!rs2_q)
		$rose(rta_q) |-> $past(mst_target_abort)) else $error("flag set by write");
	a_sel_read: assert property (@(posedge clk) disable iff (!rs2_q)
		cfg_rd && cfg_dw == 6'h01 |=> cfg_rdata[26:25] == 2'h1)
		else $error("select timing not medium");
	a_io_bits: assert property (@(posedge clk) disable iff (!rs2_q)
		cfg_rd && cfg_dw == 6'h04 |=> cfg_rdata[1:0] == 2'h1)
		else $error("io base low bits wrong");
	a_irq_fixed: assert property (@(posedge clk) disable iff (!rs2_q)
		cfg_rd && cfg_dw == 6'h0f |=> cfg_rdata[31:8] == 24'h400801)
		else $error("irq pin or grant values wrong");
	a_unmapped: assert property (@(posedge clk) disable iff (!rs2_q)
		cfg_rd && cfg_dw > 6'h05 && cfg_dw != 6'h0f |=> cfg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_lat_store: assert property (@(posedge clk) disable iff (!rs2_q)
		wr_hdr && cfg_be[1] |=> lat_q == $past(cfg_wdata[15:8]))
		else $error("latency byte not stored");
	a_tenure_end: assert property (@(posedge clk) disable iff (!rs2_q)
		ms_q == MS_BURST && mst_active && lat_cnt_q == 8'h00 && gnt_n |=> mst_stop_req)
		else $error("burst not stopped on expiry");
	a_float_rst: assert property (@(posedge clk) !rs2_q |-> !stl_oe)
		else $error("driving in reset");

	// status flags: clear, hold and set conditions
	a_dpr_clear: assert property (@(posedge clk) disable iff (!rs2_q)
		wr_stat && cfg_be[3] && cfg_wdata[24] && !(mst_perr_seen && mst_active && per_resp_en)
		|=> !dpr_q) else $error("parity flag not cleared");

	a_rta_hold: assert property (@(posedge clk) disable iff (!rs2_q)
		!mst_target_abort && !(wr_stat && cfg_be[3] && cfg_wdata[28]) |=> rta_q == $past(rta_q))
		else $error("abort flag changed without cause");

	a_dpr_hold: assert property (@(posedge clk) disable iff (!rs2_q)
		!mst_perr_seen && !(wr_stat && cfg_be[3] && cfg_wdata[24]) |=> dpr_q == $past(dpr_q))
		else $error("parity flag changed without cause");

	a_wr_no_set: assert property (@(posedge clk) disable iff (!rs2_q)
		wr_stat && !mst_target_abort && !rta_q |=> !rta_q)
		else $error("status write set a flag");

	a_dpr_need_en: assert property (@(posedge clk) disable iff (!rs2_q)
		!per_resp_en |=> !$rose(dpr_q))
		else $error("parity flag set while response disabled");

	// fixed identification and layout fields, read data hold
	a_class_read: assert property (@(posedge clk) disable iff (!rs2_q)
		cfg_rd && cfg_dw == 6'h02 |=> cfg_rdata[31:8] == 24'h010000)
		else $error("class field wrong");

	a_rev_read: assert property (@(posedge clk) disable iff (!rs2_q)
		cfg_rd && cfg_dw == 6'h02 |=> cfg_rdata[7:0] == {4'h0, SILICON_REV})
		else $error("revision byte wrong");

	a_hdr_read: assert property (@(posedge clk) disable iff (!rs2_q)
		cfg_rd && cfg_dw == 6'h03 |=> cfg_rdata[31:16] == 16'h0000)
		else $error("header type not zero");

	a_mem_bit0: assert property (@(posedge clk) disable iff (!rs2_q)
		cfg_rd && cfg_dw == 6'h05 |=> !cfg_rdata[0])
		else $error("memory base bit 0 not zero");

	a_rdata_hold: assert property (@(posedge clk) disable iff (!rs2_q)
		!cfg_rd |=> $stable(cfg_rdata))
		else $error("read data moved without a read");

	// writable stores take the enabled lanes
	a_cls_store: assert property (@(posedge clk) disable iff (!rs2_q)
		wr_hdr && cfg_be[0] |=> cls_q == $past(cfg_wdata[7:0]))
		else $error("cache line byte not stored");

	a_irq_store: assert property (@(posedge clk) disable iff (!rs2_q)
		wr_irq && cfg_be[0] |=> irq_line_q == $past(cfg_wdata[7:0]))
		else $error("interrupt line byte not stored");

	a_io_store: assert property (@(posedge clk) disable iff (!rs2_q)
		wr_io && cfg_be[3] |=> io_base_q[31:24] == $past(cfg_wdata[31:24]))
		else $error("io base not stored");

	a_mem_store: assert property (@(posedge clk) disable iff (!rs2_q)
		wr_mem && cfg_be[3] |=> mem_base_q[31:24] == $past(cfg_wdata[31:24]))
		else $error("memory base not stored");

	// tenure timer and stop request
	a_timer_load: assert property (@(posedge clk) disable iff (!rs2_q)
		mst_start |=> lat_cnt_q == $past(lat_q))
		else $error("tenure timer not loaded");

	a_timer_count: assert property (@(posedge clk) disable iff (!rs2_q)
		!mst_start && mst_active && lat_cnt_q != 8'h00 |=> lat_cnt_q == $past(lat_cnt_q) - 8'h01)
		else $error("tenure timer not counting");

	a_stop_release: assert property (@(posedge clk) disable iff (!rs2_q)
		mst_stop_req && !mst_active |=> !mst_stop_req)
		else $error("stop request outlived mastership");

	a_no_early_stop: assert property (@(posedge clk) disable iff (!rs2_q)
		ms_q == MS_BURST && lat_cnt_q != 8'h00 |=> !mst_stop_req)
		else $error("stop before timer expiry");

	a_grant_held: assert property (@(posedge clk) disable iff (!rs2_q)
		ms_q == MS_BURST && !gnt_n |=> !mst_stop_req)
		else $error("stop while grant still held");

	// burst alignment and core clock select
	a_align_block: assert property (@(posedge clk) disable iff (!rs2_q)
		cache_line_align_enable && !memory_to_memory_move && cls_q == 8'h04 &&
		mst_addr[3:2] != 2'h0 |-> !mst_may_burst) else $error("misaligned burst allowed");

	a_align_off: assert property (@(posedge clk) disable iff (!rs2_q)
		!cache_line_align_enable |-> mst_may_burst)
		else $error("burst blocked with alignment off");

	a_clk_sel: assert property (@(posedge clk) disable iff (!rs2_q)
		core_clk_is_bus == core_clk_sel_bus)
		else $error("core clock choice not reflected");

	// shared line and reset
	a_line_level: assert property (@(posedge clk) disable iff (!rs2_q)
		stl_oe |-> !stl_out_n)
		else $error("shared line driven high");

	a_one_driver: assert property (@(posedge clk) disable iff (!rs2_q)
		stl_oe |-> serr_drive)
		else $error("shared line driven without request");

	a_sync_rise: assert property (@(posedge clk)
		$rose(rs2_q) |-> $past(rs1_q))
		else $error("reset released without first stage");

	a_regs_reset: assert property (@(posedge clk)
		!rs2_q |-> !rta_q && !dpr_q && cfg_rdata == 32'h0000_0000)
		else $error("state not cleared in reset");

	c_abort: cover property (@(posedge clk) disable iff (!rs2_q) $rose(rta_q));
	c_clear: cover property (@(posedge clk) disable iff (!rs2_q) $fell(rta_q));
	c_parity: cover property (@(posedge clk) disable iff (!rs2_q) $rose(dpr_q));
	c_stop: cover property (@(posedge clk) disable iff (!rs2_q) $rose(mst_stop_req));
	c_misalign: cover property (@(posedge clk) disable iff (!rs2_q) !mst_may_burst);
endmodule : pcfg_header
`default_nettype wire

// *** dv/pcfg_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcfg_host_model (
	input  wire logic        clk,       // bus clock
	output logic             cfg_wr,    // write strobe
	output logic             cfg_rd,    // read strobe
	output logic      [5:0]  cfg_dw,    // dword index
	output logic      [3:0]  cfg_be,    // byte enables
	output logic      [31:0] cfg_wdata, // write data
	input  wire logic [31:0] cfg_rdata  // read data
);
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_dw = 6'h3f;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
	end
	// drive just after the edge so the device samples on the next rising edge
	task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		cfg_wr    <= 1'b1;
		cfg_dw    <= dw;
		cfg_be    <= be;
		cfg_wdata <= d;
		@(posedge clk);
		cfg_wr    <= 1'b0;
		cfg_be    <= ~be;
		cfg_wdata <= ~d; // released lines must not keep the old value
	endtask : wr
	task automatic rd(input logic [5:0] dw, output logic [31:0] d);
		@(posedge clk);
		cfg_rd <= 1'b1;
		cfg_dw <= dw;
		@(posedge clk);
		cfg_rd <= 1'b0;
		cfg_dw <= ~dw;
		#1;
		d = cfg_rdata;
	endtask : rd
endmodule : pcfg_host_model
`default_nettype wire

// *** dv/pci_config_header_upper_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pcfg_params.svh"
module pci_config_header_upper_tb_top;
	logic        clk, nrst, cfg_wr, cfg_rd, per_resp_en, cache_line_align_enable;
	logic        core_clk_sel_bus, core_clk_is_bus, mst_active, mst_start, mst_target_abort;
	logic        mst_perr_seen, gnt_n, memory_to_memory_move, mst_may_burst, mst_stop_req;
	logic        serr_drive, stl_out_n, stl_oe, rst_sync_n;
	logic [5:0]  cfg_dw;
	logic [3:0]  cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, mst_addr, rv;
	logic [5:0]  unmapped [4] = '{6'h06, 6'h0a, 6'h10, 6'h3f};
	int          failures, num_checks;
	pcfg_header #(.SILICON_REV(4'h3)) dut_u ( // revision value is arbitrary
		.clk, .nrst, .cfg_wr, .cfg_rd, .cfg_dw, .cfg_be, .cfg_wdata, .cfg_rdata,
		.per_resp_en, .cache_line_align_enable, .core_clk_sel_bus, .core_clk_is_bus,
		.mst_active, .mst_start, .mst_target_abort, .mst_perr_seen, .gnt_n, .mst_addr,
		.memory_to_memory_move, .mst_may_burst, .mst_stop_req, .serr_drive, .stl_out_n,
		.stl_oe, .rst_sync_n);
	pcfg_host_model host_u (.clk, .cfg_wr, .cfg_rd, .cfg_dw, .cfg_be, .cfg_wdata, .cfg_rdata);
	task automatic chk32(input logic [5:0] dw, input logic [31:0] exp);
		host_u.rd(dw, rv);
		num_checks++;
		if (rv !== exp) begin
			failures++;
			$display("wrong value at %0t: dword %h read %h not %h", $time, dw, rv, exp);
		end
	endtask : chk32
	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: flag %b not %b", $time, got, exp);
		end
	endtask : chk1
	task automatic test_done;
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// whole run is well under 1000 cycles
	initial begin
		#100us;
		failures++;
		test_done();
	end
	initial begin
		nrst = 1'b0;
		gnt_n = 1'b1;
		serr_drive = 1'b1;
		mst_addr = 32'h0;
		{per_resp_en, cache_line_align_enable, core_clk_sel_bus, mst_active} = 4'h0;
		{mst_start, mst_target_abort, mst_perr_seen, memory_to_memory_move} = 4'h0;
		repeat (5) @(posedge clk);
		#1;
		chk1(stl_oe, 1'b0);
		@(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		#1;
		chk1(rst_sync_n, 1'b0);
		@(posedge clk);
		#1;
		chk1(rst_sync_n, 1'b1);
		chk1(stl_oe, 1'b1);
		chk1(stl_out_n, 1'b0);
		chk1(core_clk_is_bus, 1'b0);
		@(posedge clk);
		serr_drive <= 1'b0;
		core_clk_sel_bus <= 1'b1;
		#1;
		chk1(stl_oe, 1'b0);
		chk1(core_clk_is_bus, 1'b1);
		chk32(`PCFG_DW_STATCMD, 32'h02000000);
		@(posedge clk);
		mst_target_abort <= 1'b1;
		@(posedge clk);
		mst_target_abort <= 1'b0;
		chk32(`PCFG_DW_STATCMD, 32'h12000000);
		host_u.wr(`PCFG_DW_STATCMD, 4'h8, 32'h06000000);
		chk32(`PCFG_DW_STATCMD, 32'h12000000);
		host_u.wr(`PCFG_DW_STATCMD, 4'h8, 32'h10000000);
		chk32(`PCFG_DW_STATCMD, 32'h02000000);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			{mst_active, per_resp_en, mst_perr_seen} <= {i[1:0], 1'b1};
			@(posedge clk);
			mst_perr_seen <= 1'b0;
			chk32(`PCFG_DW_STATCMD, {7'h01, i == 3, 24'h0});
			host_u.wr(`PCFG_DW_STATCMD, 4'h8, 32'h01000000);
		end
		mst_active <= 1'b0;
		chk32(`PCFG_DW_CLASSREV, 32'h01000003);
		host_u.wr(`PCFG_DW_CLASSREV, 4'hf, 32'hffffffff);
		chk32(`PCFG_DW_CLASSREV, 32'h01000003);
		chk32(`PCFG_DW_HDRMISC, 32'h0);
		host_u.wr(`PCFG_DW_HDRMISC, 4'hf, 32'hffffffff);
		chk32(`PCFG_DW_HDRMISC, 32'h0000ffff);
		chk32(`PCFG_DW_IOBASE, 32'h00000001);
		host_u.wr(`PCFG_DW_IOBASE, 4'hf, 32'hffffffff);
		chk32(`PCFG_DW_IOBASE, 32'hfffffffd);
		host_u.wr(`PCFG_DW_MEMBASE, 4'hf, 32'hffffffff);
		chk32(`PCFG_DW_MEMBASE, 32'hfffffffe);
		chk32(`PCFG_DW_IRQ, 32'h40080100);
		host_u.wr(`PCFG_DW_IRQ, 4'h1, 32'hffffff5a);
		chk32(`PCFG_DW_IRQ, 32'h4008015a);
		foreach (unmapped[i]) begin
			host_u.wr(unmapped[i], 4'hf, 32'hffffffff);
			chk32(unmapped[i], 32'h0);
		end
		host_u.wr(`PCFG_DW_HDRMISC, 4'h3, 32'h00000304);
		chk32(`PCFG_DW_HDRMISC, 32'h00000304);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			cache_line_align_enable <= i != 3;
			memory_to_memory_move <= i == 2;
			mst_addr <= (i == 0) ? 32'h10 : 32'h14;
			#1;
			chk1(mst_may_burst, i != 1);
		end
		for (int g = 1; g >= 0; g--) begin
			@(posedge clk);
			{mst_active, mst_start, gnt_n} <= {2'h3, g[0]};
			@(posedge clk);
			mst_start <= 1'b0;
			repeat (2) @(posedge clk);
			#1;
			chk1(mst_stop_req, 1'b0);
			repeat (6) @(posedge clk);
			#1;
			chk1(mst_stop_req, g[0]);
			gnt_n <= 1'b1;
			repeat (3) @(posedge clk);
			#1;
			chk1(mst_stop_req, 1'b1);
			mst_active <= 1'b0;
			@(posedge clk);
			#1;
			chk1(mst_stop_req, 1'b0);
		end
		test_done();
	end
endmodule : pci_config_header_upper_tb_top
`default_nettype wire
